// >>> logic/warn_mask_consts.vh
// Register offsets, field positions and reset values of the warning and mask register bank.
`ifndef WARN_MASK_CONSTS_VH
`define WARN_MASK_CONSTS_VH
`define ADDR_WARNING_FLAGS 8'h13
`define ADDR_PIN_REPORT_ENABLES 8'h14
`define ADDR_AC_DIAG_CONTROL_ONE 8'h15
`define ADDR_AC_DIAG_CONTROL_TWO 8'h16
`define RST_PIN_REPORT_ENABLES 8'hff
`define RST_AC_DIAG_CONTROL_ONE 8'h00
`define RST_AC_DIAG_CONTROL_TWO 8'h00
`define BIT_SUPPLY_POR 5
`define BIT_GLOBAL_WARN 4
`define BIT_CH1_WARN 3
`define BIT_CH2_WARN 2
`define BIT_CH3_WARN 1
`define BIT_CH4_WARN 0
`define BIT_REP_OC 7
`define BIT_REP_SHUTDOWN 6
`define BIT_REP_HIGH 5
`define BIT_REP_LOW 4
`define BIT_REP_DC 3
`define BIT_REP_ILIM 2
`define BIT_REP_CLIP 1
`define BIT_REP_THERM 0
`define BIT_GAIN_A 7
`define BIT_GAIN_B 5
`define BIT_LOOP 7
`define BIT_MEAS_LEN 4
`define CUR_HI 3
`define CUR_LO 2
`define MASK_CTRL_ONE 8'haf
`define MASK_CTRL_TWO 8'h9c
`define CUR_10MA 2'h0
`define CUR_19MA 2'h1
`endif

// >>> logic/warning_mask_acdiag_regs.v
// Warning flags, pin report enables and AC diagnostic control registers.
// Notes on behaviour
// [R1] Warning bit 5 shows whether a core supply power-on reset has occurred.
// [R2] Warning bit 4 follows the global overtemperature warning.
// [R3] Warning bits 3 to 0 show per-channel overtemperature warnings.
// [R4] Pin control bit 7 lets overcurrent faults reach the fault pin.
// [R5] Pin control bit 6 lets thermal shutdown faults reach the fault pin.
// [R6] Pin control bit 5 lets supply overvoltage faults reach the fault pin.
// [R7] Pin control bit 4 lets supply undervoltage faults reach the fault pin.
// [R8] Pin control bit 3 lets DC offset faults reach the fault pin.
// [R9] Pin control bit 2 lets current limit events reach the fault pin.
// [R10] Pin control bit 1 lets clipping reach the warning pin.
// [R11] Pin control bit 0 lets overtemperature warnings reach the warning pin.
// [R12] Control one bit 7 selects gain 1 or 4 for channel pair one-two.
// [R13] Control one bit 5 selects gain for pair three-four; bits 6, 4 read zero.
// [R14] Control one bits 3 to 0 enable AC diagnostic on channels 1 to 4.
// [R15] Control two bit 7 enables the diagnostic loopback path.
// [R16] Control two bit 4 picks 32 or 64 cycles; bits 3:2 pick test current.
// [R17] Warning flags ignore writes; enabled classes drive the fault and warning pins.
`timescale 1ns/10ps
`include "warn_mask_consts.vh"
module warning_mask_acdiag_regs
(
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Register access port
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata,
   output reg regRvalid,
   // Condition inputs from the protection circuits, active high
   input wire supplyPorSeen,
   input wire global_thermal_warning,
   input wire [3:0] chThermalWarning,
   input wire overcurrentFault,
   input wire thermalShutdownFault,
   input wire supplyHighFault,
   input wire supplyLowFault,
   input wire offsetFault,
   input wire currentLimitEvent,
   input wire clipEvent,
   // Report pins, active low as open-drain style flags
   output reg faultPinN,
   output reg warnPinN,
   // Diagnostic settings
   output reg pair_a_meas_gain,
   output reg pair_b_meas_gain,
   output reg [3:0] chAcdiagEn,
   output reg acdiag_loop_en,
   output reg acdiag_meas_length,
   output reg [1:0] acdiag_test_current
);

   // Synchroniser chains: bit 0 takes the pin, bits 1 and 2 are the second and third stages.
   reg [2:0] porSync;
   reg [2:0] globalSync;
   reg [2:0] ch1Sync;
   reg [2:0] ch2Sync;
   reg [2:0] ch3Sync;
   reg [2:0] ch4Sync;
   reg [2:0] overcurrentSync;
   reg [2:0] shutdownSync;
   reg [2:0] highSync;
   reg [2:0] lowSync;
   reg [2:0] offsetSync;
   reg [2:0] limitSync;
   reg [2:0] clipSync;
   // Condition levels accepted once the chains agree; channel 1 sits in bit 0.
   reg porLevel;
   reg globalLevel;
   reg [3:0] chWarnLevel;
   reg overcurrentLevel;
   reg shutdownLevel;
   reg highLevel;
   reg lowLevel;
   reg offsetLevel;
   reg limitLevel;
   reg clipLevel;
   // Register contents and the values that feed the output flops.
   reg [7:0] pinReportEnables;
   reg [7:0] acDiagControlOne;
   reg [7:0] acDiagControlTwo;
   reg [7:0] warningFlags;
   wire anyThermalWarning;
   reg next_fault;
   reg next_warn;
   reg [7:0] next_rdata;

   // Moves a pin one place into its chain.
   function [2:0] shift_in;
      input [2:0] chain;
      input pin;
   begin
      shift_in = {chain[1:0], pin};
   end
   endfunction

   // A new level counts only when the second and third stages agree, so a pin that
   // changes right at the sampling edge cannot pass a half-settled value.
   function settle;
      input held;
      input [2:0] chain;
   begin
      if (chain[2] == chain[1])
         settle = chain[2];
      else
         settle = held;
   end
   endfunction

   // One fault or warning class reaches its pin only while its enable bit is set.
   function reported;
      input level;
      input enable;
   begin
      reported = level & enable;
   end
   endfunction

   // Pins from outside the clock domain pass three flops before they are used.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         porSync <= 3'h0;
         globalSync <= 3'h0;
         ch1Sync <= 3'h0;
         ch2Sync <= 3'h0;
         ch3Sync <= 3'h0;
         ch4Sync <= 3'h0;
         overcurrentSync <= 3'h0;
         shutdownSync <= 3'h0;
         highSync <= 3'h0;
         lowSync <= 3'h0;
         offsetSync <= 3'h0;
         limitSync <= 3'h0;
         clipSync <= 3'h0;
      end
      else
      begin
         porSync <= shift_in(porSync, supplyPorSeen);
         globalSync <= shift_in(globalSync, global_thermal_warning);
         ch1Sync <= shift_in(ch1Sync, chThermalWarning[0]);
         ch2Sync <= shift_in(ch2Sync, chThermalWarning[1]);
         ch3Sync <= shift_in(ch3Sync, chThermalWarning[2]);
         ch4Sync <= shift_in(ch4Sync, chThermalWarning[3]);
         overcurrentSync <= shift_in(overcurrentSync, overcurrentFault);
         shutdownSync <= shift_in(shutdownSync, thermalShutdownFault);
         highSync <= shift_in(highSync, supplyHighFault);
         lowSync <= shift_in(lowSync, supplyLowFault);
         offsetSync <= shift_in(offsetSync, offsetFault);
         limitSync <= shift_in(limitSync, currentLimitEvent);
         clipSync <= shift_in(clipSync, clipEvent);
      end
   end

   // Levels are cleared in reset, so neither pin reports before the chains have filled.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         porLevel <= 1'b0;
         globalLevel <= 1'b0;
         chWarnLevel <= 4'h0;
         overcurrentLevel <= 1'b0;
         shutdownLevel <= 1'b0;
         highLevel <= 1'b0;
         lowLevel <= 1'b0;
         offsetLevel <= 1'b0;
         limitLevel <= 1'b0;
         clipLevel <= 1'b0;
      end
      else
      begin
         porLevel <= settle(porLevel, porSync); // [R1]
         globalLevel <= settle(globalLevel, globalSync); // [R2]
         chWarnLevel[0] <= settle(chWarnLevel[0], ch1Sync); // [R3]
         chWarnLevel[1] <= settle(chWarnLevel[1], ch2Sync); // [R3]
         chWarnLevel[2] <= settle(chWarnLevel[2], ch3Sync); // [R3]
         chWarnLevel[3] <= settle(chWarnLevel[3], ch4Sync); // [R3]
         overcurrentLevel <= settle(overcurrentLevel, overcurrentSync);
         shutdownLevel <= settle(shutdownLevel, shutdownSync);
         highLevel <= settle(highLevel, highSync);
         lowLevel <= settle(lowLevel, lowSync);
         offsetLevel <= settle(offsetLevel, offsetSync);
         limitLevel <= settle(limitLevel, limitSync);
         clipLevel <= settle(clipLevel, clipSync);
      end
   end

   // Reserved bits 7:6 read zero.
   always @*
   begin
      warningFlags = 8'h00;
      warningFlags[`BIT_SUPPLY_POR] = porLevel; // [R1]
      warningFlags[`BIT_GLOBAL_WARN] = globalLevel; // [R2]
      warningFlags[`BIT_CH1_WARN] = chWarnLevel[0]; // [R3]
      warningFlags[`BIT_CH2_WARN] = chWarnLevel[1]; // [R3]
      warningFlags[`BIT_CH3_WARN] = chWarnLevel[2]; // [R3]
      warningFlags[`BIT_CH4_WARN] = chWarnLevel[3]; // [R3]
   end

   // The warning pin treats the global warning and every channel warning alike.
   assign anyThermalWarning = globalLevel | (|chWarnLevel);

   always @*
   begin
      next_fault = reported(overcurrentLevel, pinReportEnables[`BIT_REP_OC]) | // [R4]
                   reported(shutdownLevel, pinReportEnables[`BIT_REP_SHUTDOWN]) | // [R5]
                   reported(highLevel, pinReportEnables[`BIT_REP_HIGH]) | // [R6]
                   reported(lowLevel, pinReportEnables[`BIT_REP_LOW]) | // [R7]
                   reported(offsetLevel, pinReportEnables[`BIT_REP_DC]) | // [R8]
                   reported(limitLevel, pinReportEnables[`BIT_REP_ILIM]); // [R9] [R17]
      next_warn = reported(clipLevel, pinReportEnables[`BIT_REP_CLIP]) | // [R10]
                  reported(anyThermalWarning, pinReportEnables[`BIT_REP_THERM]); // [R11] [R17]
   end

   // Read data is chosen from the address alone; unmapped offsets read zero.
   always @*
   begin
      case (regAddr)
         `ADDR_WARNING_FLAGS: next_rdata = warningFlags;
         `ADDR_PIN_REPORT_ENABLES: next_rdata = pinReportEnables;
         `ADDR_AC_DIAG_CONTROL_ONE: next_rdata = acDiagControlOne;
         `ADDR_AC_DIAG_CONTROL_TWO: next_rdata = acDiagControlTwo;
         default: next_rdata = 8'h00;
      endcase
   end

   // Register writes; the warning offset has no write path, so writes there are dropped.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         pinReportEnables <= `RST_PIN_REPORT_ENABLES;
         acDiagControlOne <= `RST_AC_DIAG_CONTROL_ONE;
         acDiagControlTwo <= `RST_AC_DIAG_CONTROL_TWO;
      end
      else if (regWrite)
      begin
         case (regAddr)
            `ADDR_PIN_REPORT_ENABLES: pinReportEnables <= regWdata;
            `ADDR_AC_DIAG_CONTROL_ONE: acDiagControlOne <= regWdata & `MASK_CTRL_ONE; // [R13]
            `ADDR_AC_DIAG_CONTROL_TWO: acDiagControlTwo <= regWdata & `MASK_CTRL_TWO; // [R16]
            default: pinReportEnables <= pinReportEnables; // [R17]
         endcase
      end
   end

   // Read port: the answer flag stands for one cycle, the data until the next read.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         regRdata <= 8'h00;
         regRvalid <= 1'b0;
      end
      else
      begin
         regRvalid <= regRead;
         if (regRead)
            regRdata <= next_rdata;
      end
   end

   // Pins are registered so they stay glitch-free while enables change; both are active low.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         faultPinN <= 1'b1;
         warnPinN <= 1'b1;
      end
      else
      begin
         faultPinN <= ~next_fault;
         warnPinN <= ~next_warn;
      end
   end

   // Diagnostic settings trail their register by one cycle.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         pair_a_meas_gain <= 1'b0;
         pair_b_meas_gain <= 1'b0;
         chAcdiagEn <= 4'h0;
         acdiag_loop_en <= 1'b0;
         acdiag_meas_length <= 1'b0;
         acdiag_test_current <= `CUR_10MA;
      end
      else
      begin
         pair_a_meas_gain <= acDiagControlOne[`BIT_GAIN_A]; // [R12]
         pair_b_meas_gain <= acDiagControlOne[`BIT_GAIN_B]; // [R13]
         chAcdiagEn <= {acDiagControlOne[0], acDiagControlOne[1],
                        acDiagControlOne[2], acDiagControlOne[3]}; // [R14]
         acdiag_loop_en <= acDiagControlTwo[`BIT_LOOP]; // [R15]
         acdiag_meas_length <= acDiagControlTwo[`BIT_MEAS_LEN]; // [R16]
         // Reserved current codes are passed as written; software must not use them.
         acdiag_test_current <= acDiagControlTwo[`CUR_HI:`CUR_LO]; // [R16]
      end
   end

endmodule // warning_mask_acdiag_regs

// >>> verification/warn_mask_checker_assertions.sv
// Concurrent checks on the register port and the diagnostic setting outputs.
`timescale 1ns/10ps
module warn_mask_checker
(
   // Clock, reset and register port
   input wire clk,
   input wire rstn,
   input wire regWrite,
   input wire regRead,
   input wire regRvalid,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire [7:0] regRdata,
   // Diagnostic settings
   input wire pair_a_meas_gain,
   input wire pair_b_meas_gain,
   input wire acdiag_loop_en,
   input wire acdiag_meas_length,
   input wire [3:0] chAcdiagEn,
   input wire [1:0] acdiag_test_current
);
   reg [7:0] w1;
   reg [7:0] w2;
   wire wrOne = regWrite && regAddr == 8'h15;
   wire wrTwo = regWrite && regAddr == 8'h16;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Settings trail the register by one edge, so write data is delayed by two to line up.
   always @(posedge clk)
   begin
      w1 <= regWdata;
      w2 <= w1;
   end
   a_read_answer: assert property (regRead |=> regRvalid)
      else $error("read not answered");
   a_answer_cause: assert property (regRvalid |-> $past(regRead))
      else $error("read valid without a read");
   a_unmapped_zero: assert property (regRead && (regAddr < 8'h13 || regAddr > 8'h16)
      |=> regRdata == 8'h00) else $error("unmapped read not zero");
   a_gain_pair_a: assert property (wrOne |=> ##1 pair_a_meas_gain == w2[7])
      else $error("pair a gain wrong");
   a_gain_pair_b: assert property (wrOne |=> ##1 pair_b_meas_gain == w2[5])
      else $error("pair b gain wrong");
   a_diag_enables: assert property (wrOne |=> ##1
      chAcdiagEn == {w2[0], w2[1], w2[2], w2[3]})
      else $error("channel enables wrong");
   a_loop_follow: assert property (wrTwo |=> ##1 acdiag_loop_en == w2[7])
      else $error("loopback wrong");
   a_length_current: assert property (wrTwo |=> ##1
      {acdiag_meas_length, acdiag_test_current} == {w2[4], w2[3:2]})
      else $error("length or current wrong");
   c_write_one: cover property (wrOne);
   c_write_two: cover property (wrTwo);
   c_flag_read: cover property (regRead && regAddr == 8'h13);
endmodule // warn_mask_checker
bind warning_mask_acdiag_regs warn_mask_checker u_warn_mask_checker (.*);

// >>> verification/warning_mask_acdiag_regs_tb.sv
// Self-checking bench for the warning flags, pin report enables and diagnostic controls.
`timescale 1ns/10ps
module warning_mask_acdiag_regs_tb;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg regWrite = 1'b0;
   reg regRead = 1'b0;
   reg [7:0] regAddr = 8'h00;
   reg [7:0] regWdata = 8'h00;
   reg [12:0] cond = 13'h0000;
   wire [7:0] regRdata;
   wire regRvalid, faultPinN, warnPinN, gainA, gainB, loopEn, measLen;
   wire [3:0] acEn;
   wire [1:0] testCur;
   integer fails = 0;
   integer checks = 0;
   integer i, j;
   always #2 clk = ~clk;
   warning_mask_acdiag_regs u_warning_mask_acdiag_regs
   (
      .clk(clk), .rstn(rstn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
      .supplyPorSeen(cond[12]), .global_thermal_warning(cond[11]), .chThermalWarning(cond[10:7]),
      .overcurrentFault(cond[6]), .thermalShutdownFault(cond[5]), .supplyHighFault(cond[4]),
      .supplyLowFault(cond[3]), .offsetFault(cond[2]), .currentLimitEvent(cond[1]),
      .clipEvent(cond[0]), .faultPinN(faultPinN), .warnPinN(warnPinN), .pair_a_meas_gain(gainA),
      .pair_b_meas_gain(gainB), .chAcdiagEn(acEn), .acdiag_loop_en(loopEn),
      .acdiag_meas_length(measLen), .acdiag_test_current(testCur)
   );
   task chk(input [7:0] seen, input [7:0] exp);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task report_and_stop;
   begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge clk);
      #1 regWrite = 1'b1;
      regAddr = a;
      regWdata = d;
      @(posedge clk);
      #1 regWrite = 1'b0;
   end
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      integer n;
   begin
      @(posedge clk);
      #1 regRead = 1'b1;
      regAddr = a;
      @(posedge clk);
      #1 regRead = 1'b0;
      for (n = 0; regRvalid !== 1'b1 && n < 4; n = n + 1)
         @(posedge clk);
      if (regRvalid !== 1'b1)
      begin
         chk(8'h00, 8'h01);
         report_and_stop;
      end
      else
         chk(regRdata, exp);
   end
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      #1 rstn = 1'b1;
      rd(8'h14, 8'hff);
      rd(8'h15, 8'h00);
      rd(8'h16, 8'h00);
      wr(8'h15, 8'hff);
      rd(8'h15, 8'haf);
      chk({gainA, gainB, 2'b00, acEn}, 8'hcf);
      wr(8'h15, 8'h08);
      // Current codes 10 and 11 are reserved, so only 01 and 00 are ever written.
      wr(8'h16, 8'hf7);
      rd(8'h16, 8'h94);
      chk({gainA, gainB, loopEn, measLen, acEn}, 8'h31);
      chk({6'h00, testCur}, 8'h01);
      wr(8'h16, 8'h00);
      wr(8'h40, 8'hff);
      rd(8'h40, 8'h00);
      chk({4'h0, loopEn, measLen, testCur}, 8'h00);
      $display("test controls done");
      // Conditions pass three synchroniser flops, so they are given time to settle.
      cond = 13'h1880;
      repeat (6) @(posedge clk);
      wr(8'h13, 8'h00);
      rd(8'h13, 8'h38);
      chk({7'h00, warnPinN}, 8'h00);
      cond = 13'h0400;
      repeat (6) @(posedge clk);
      rd(8'h13, 8'h01);
      $display("test warning flags done");
      // Each class is tried alone so a crossed enable bit shows on the wrong pin.
      for (i = 0; i < 8; i = i + 1)
      begin
         j = (i > 1) ? i - 1 : 11 * (1 - i);
         cond = 13'h0000;
         cond[j] = 1'b1;
         wr(8'h14, ~(8'h01 << i));
         repeat (6) @(posedge clk);
         #1 chk({7'h00, (i > 1) ? faultPinN : warnPinN}, 8'h01);
         wr(8'h14, 8'h01 << i);
         repeat (6) @(posedge clk);
         #1 chk({7'h00, (i > 1) ? faultPinN : warnPinN}, 8'h00);
      end
      $display("test pin reporting done");
      report_and_stop;
   end
endmodule // warning_mask_acdiag_regs_tb
